//--- tsp_serial_link.sv
`timescale 1ns/100ps
`include "tsp_cfg.svh"
module tsp_serial_link
  import tsp_pkg::*;
(
  input  wire logic   sclk,
  input  wire logic   nrst,
  input  wire logic   cs_n,
  input  wire logic   cmd_data,
  output logic        reply_o,
  output logic        reply_oe,
  tsp_link_if.link    lnk
);

  tsp_frame_t fr_q;
  tsp_frame_t fr_d;
  tsp_evt_t   ev_q;
  tsp_evt_t   ev_d;
  logic       out_q;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       wr_done;
  logic       rd_done;

  function automatic logic is_tone(input logic [7:0] c);
    is_tone = (c == `TSP_CMD_WR_TONE1) || (c == `TSP_CMD_WR_TONE2);
  endfunction : is_tone

  ////////////////////////////////////////////////////////////////////////////
  // Frame logic, cleared whenever chip select is high
  always_comb begin
    fr_d      = fr_q;
    byte_in   = {fr_q.shift_q, cmd_data};
    byte_done = (fr_q.bitcnt_q == `TSP_LAST_BIT);
    wr_done   = 1'b0;
    rd_done   = 1'b0;
    fr_d.bitcnt_q = fr_q.bitcnt_q + 3'h1;
    fr_d.shift_q  = byte_in[6:0];
    if (fr_q.ract_q) begin
      fr_d.rsr_q = {fr_q.rsr_q[6:0], 1'b0};
    end
    if (byte_done) begin
      if (fr_q.nbytes_q != 2'h3) begin
        fr_d.nbytes_q = fr_q.nbytes_q + 2'h1;
      end
      unique case (fr_q.nbytes_q)
        2'h0: begin
          fr_d.cmd_q = byte_in;
          if (byte_in == `TSP_CMD_RD_STATUS) begin
            fr_d.rsr_q  = lnk.snap;
            fr_d.ract_q = 1'b1;
          end
        end
        2'h1: begin
          fr_d.data_q[15:8] = byte_in;
          wr_done = (fr_q.cmd_q == `TSP_CMD_WR_CTRL);
          rd_done = fr_q.ract_q;
          if (fr_q.ract_q) begin
            fr_d.ract_q = 1'b0;
          end
        end
        2'h2: begin
          fr_d.data_q[7:0] = byte_in;
          wr_done = is_tone(fr_q.cmd_q);
        end
        2'h3: begin
        end
      endcase
    end
  end

  // Chip select high aborts any partial frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion toggles toward the core clock
  // Written word held past chip select release until the next write
  always_comb begin
    ev_d = ev_q;
    if (!cs_n && wr_done) begin
      ev_d.wr_tgl_q = ~ev_q.wr_tgl_q;
      ev_d.cmd_q    = fr_d.cmd_q;
      ev_d.data_q   = fr_d.data_q;
    end
    if (!cs_n && rd_done) begin
      ev_d.rd_tgl_q = ~ev_q.rd_tgl_q;
    end
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply bit launched on falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= fr_q.rsr_q[7];
    end
  end

  assign reply_o    = out_q;
  assign reply_oe   = !cs_n && fr_q.ract_q;
  assign lnk.cmd    = ev_q.cmd_q;
  assign lnk.data   = ev_q.data_q;
  assign lnk.wr_tgl = ev_q.wr_tgl_q;
  assign lnk.rd_tgl = ev_q.rd_tgl_q;

endmodule : tsp_serial_link

//--- tsp_cfg.svh
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH

// Command codes, first byte of a frame
`define TSP_CMD_WR_CTRL   8'h30
`define TSP_CMD_WR_TONE1  8'h31
`define TSP_CMD_WR_TONE2  8'h32
`define TSP_CMD_RD_STATUS 8'h40

// Control byte fields
`define TSP_CTRL_SUM_SW   4
`define TSP_CTRL_TMR_EN   5
`define TSP_CTRL_RX_EN    6
`define TSP_CTRL_AUD_SW   7
`define TSP_CTRL_RST      8'h00

// Status byte fields
`define TSP_ST_GP         0
`define TSP_ST_NOTONE     1
`define TSP_ST_RXMEAS     2
`define TSP_ST_LOGIC      3

// Tone word reset value
`define TSP_TONE_RST      16'h0000

// Byte geometry
`define TSP_LAST_BIT      3'h7

`endif

//--- tsp_pkg.sv
package tsp_pkg;

  typedef struct packed {
    logic [2:0]  evt_q;
    logic [7:0]  ctrl_q;
    logic [15:0] tone1_q;
    logic [15:0] tone2_q;
    logic [7:0]  snap_q;
    logic [2:0]  wr_s_q;
    logic [2:0]  rd_s_q;
    logic [1:0]  cs_s_q;
    logic [1:0]  lin_s_q;
    logic        irq_q;
  } tsp_core_t;

  typedef struct packed {
    logic [2:0]  bitcnt_q;
    logic [6:0]  shift_q;
    logic [1:0]  nbytes_q;
    logic [7:0]  cmd_q;
    logic [15:0] data_q;
    logic [7:0]  rsr_q;
    logic        ract_q;
  } tsp_frame_t;

  typedef struct packed {
    logic        wr_tgl_q;
    logic        rd_tgl_q;
    logic [7:0]  cmd_q;
    logic [15:0] data_q;
  } tsp_evt_t;

endpackage : tsp_pkg

//--- tsp_link_if.sv
`timescale 1ns/100ps
interface tsp_link_if;
  logic [7:0]  cmd;
  logic [15:0] data;
  logic        wr_tgl;
  logic        rd_tgl;
  logic [7:0]  snap;

  modport link (output cmd, output data, output wr_tgl, output rd_tgl, input snap);
  modport core (input cmd, input data, input wr_tgl, input rd_tgl, output snap);
endinterface : tsp_link_if

//--- tsp_host_port.sv
`timescale 1ns/100ps
`include "tsp_cfg.svh"
module tsp_host_port
  import tsp_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        CMD_DATA,
  output logic             REPLY_DATA_O,
  output logic             REPLY_DATA_OE,
  output logic             IRQ_N_O,
  output logic             IRQ_N_OE,
  input  wire logic        LOGIC_IN,
  input  wire logic        GP_TMR_EVT,
  input  wire logic        NOTONE_EVT,
  input  wire logic        RX_MEAS_EVT,
  input  wire logic        GP_TMR_PSAVE,
  input  wire logic        NOTONE_PSAVE,
  input  wire logic        RX_MEAS_PSAVE,
  output logic             AUDIO_SW_EN,
  output logic             SUM_SW_EN,
  output logic [15:0]      TONE1_WORD,
  output logic [15:0]      TONE2_WORD,
  output logic [2:0]       EVENT_FLAGS
);

  tsp_core_t  st_q;
  tsp_core_t  st_d;
  logic [2:0] evt_in;
  logic [2:0] psave;
  logic [2:0] src_en;
  logic       wr_evt;
  logic       rd_evt;

  tsp_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////////
  // Serial side on the host clock
  tsp_serial_link u_link (
    .sclk     (SCLK),
    .nrst     (NRST),
    .cs_n     (CS_N),
    .cmd_data (CMD_DATA),
    .reply_o  (REPLY_DATA_O),
    .reply_oe (REPLY_DATA_OE),
    .lnk      (lnk.link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core state
  always_comb begin
    st_d   = st_q;
    evt_in = {RX_MEAS_EVT, NOTONE_EVT, GP_TMR_EVT};
    psave  = {RX_MEAS_PSAVE, NOTONE_PSAVE, GP_TMR_PSAVE};
    src_en = {st_q.ctrl_q[`TSP_CTRL_RX_EN], st_q.ctrl_q[`TSP_CTRL_TMR_EN],
              st_q.ctrl_q[`TSP_CTRL_TMR_EN]};

    // Synchronisers
    st_d.wr_s_q  = {st_q.wr_s_q[1:0], lnk.wr_tgl};
    st_d.rd_s_q  = {st_q.rd_s_q[1:0], lnk.rd_tgl};
    st_d.cs_s_q  = {st_q.cs_s_q[0], CS_N};
    st_d.lin_s_q = {st_q.lin_s_q[0], LOGIC_IN};
    wr_evt = st_q.wr_s_q[2] ^ st_q.wr_s_q[1];
    rd_evt = st_q.rd_s_q[2] ^ st_q.rd_s_q[1];

    // Completed writes
    if (wr_evt) begin
      unique case (lnk.cmd)
        `TSP_CMD_WR_CTRL: st_d.ctrl_q = lnk.data[15:8];
        `TSP_CMD_WR_TONE1: st_d.tone1_q = lnk.data;
        `TSP_CMD_WR_TONE2: st_d.tone2_q = lnk.data;
        default: begin
        end
      endcase
    end

    // Status read clears reported flags; a new event wins
    if (rd_evt) begin
      st_d.evt_q = st_q.evt_q & ~st_q.snap_q[2:0];
    end
    st_d.evt_q = st_d.evt_q | (evt_in & ~psave);

    // Snapshot frozen while a frame is open
    if (st_q.cs_s_q[1]) begin
      st_d.snap_q = 8'h00;
      st_d.snap_q[`TSP_ST_GP]     = st_q.evt_q[0];
      st_d.snap_q[`TSP_ST_NOTONE] = st_q.evt_q[1];
      st_d.snap_q[`TSP_ST_RXMEAS] = st_q.evt_q[2];
      st_d.snap_q[`TSP_ST_LOGIC]  = st_q.lin_s_q[1];
    end

    st_d.irq_q = |(st_q.evt_q & src_en & ~psave);
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_q         <= '0;
      st_q.ctrl_q  <= `TSP_CTRL_RST;
      st_q.tone1_q <= `TSP_TONE_RST;
      st_q.tone2_q <= `TSP_TONE_RST;
      st_q.cs_s_q  <= 2'h3;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign lnk.snap    = st_q.snap_q;
  assign IRQ_N_O     = 1'b0;
  assign IRQ_N_OE    = st_q.irq_q;
  assign AUDIO_SW_EN = st_q.ctrl_q[`TSP_CTRL_AUD_SW];
  assign SUM_SW_EN   = st_q.ctrl_q[`TSP_CTRL_SUM_SW];
  assign TONE1_WORD  = st_q.tone1_q;
  assign TONE2_WORD  = st_q.tone2_q;
  assign EVENT_FLAGS = st_q.evt_q;

endmodule : tsp_host_port

//--- tsp_host_model.sv
`timescale 1ns/100ps
module tsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      cmd_data,
  input  wire logic reply
);
  initial begin
    sclk = 0;
    cs_n = 1;
    cmd_data = 0;
  end
  task frame(input logic [23:0] w, input int n, output logic [7:0] r);
    int i;
    r = 8'h00;
    #1 cs_n = 0;
    #60;
    for (i = 0; i < n; i++) begin
      cmd_data = w[23-i];
      #3 if (i > 7) r = {r[6:0], reply};
      sclk = 1;
      #3 sclk = 0;
    end
    #3 cs_n = 1;
    cmd_data = ~cmd_data;
    #200;
  endtask : frame
endmodule : tsp_host_model

//--- tsp_host_port_monitor.sv
`timescale 1ns/100ps
module tsp_host_port_monitor (
  input wire logic       MCLK,
  input wire logic       NRST,
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic       REPLY_DATA_OE,
  input wire logic       IRQ_N_O,
  input wire logic       IRQ_N_OE,
  input wire logic       GP_TMR_EVT,
  input wire logic       GP_TMR_PSAVE,
  input wire logic       RX_MEAS_PSAVE,
  input wire logic [2:0] EVENT_FLAGS
);
  reply_idle_a: assert property (
    @(posedge MCLK) disable iff (!NRST) CS_N |-> !REPLY_DATA_OE) else $error("reply driven idle");
  reply_frame_a: assert property (
    @(posedge SCLK) disable iff (!NRST) REPLY_DATA_OE |-> !CS_N) else $error("reply off frame");
  irq_level_a: assert property (
    @(posedge MCLK) disable iff (!NRST) !IRQ_N_O) else $error("irq drives high");
  irq_cause_a: assert property (
    @(posedge MCLK) disable iff (!NRST) IRQ_N_OE |-> $past(EVENT_FLAGS) != 3'h0)
    else $error("irq without flag");
  irq_release_a: assert property (
    @(posedge MCLK) disable iff (!NRST) EVENT_FLAGS == 3'h0 |=> !IRQ_N_OE)
    else $error("irq not released");
  gp_flag_a: assert property (
    @(posedge MCLK) disable iff (!NRST) GP_TMR_EVT && !GP_TMR_PSAVE |-> ##[1:2] EVENT_FLAGS[0])
    else $error("gp flag missing");
  gp_save_a: assert property (
    @(posedge MCLK) disable iff (!NRST) GP_TMR_PSAVE && !EVENT_FLAGS[0] |=> !EVENT_FLAGS[0])
    else $error("gp flag in save");
  rx_save_a: assert property (
    @(posedge MCLK) disable iff (!NRST) RX_MEAS_PSAVE && !EVENT_FLAGS[2] |=> !EVENT_FLAGS[2])
    else $error("rx flag in save");
endmodule : tsp_host_port_monitor
bind tsp_host_port tsp_host_port_monitor u_mon (.MCLK(MCLK), .NRST(NRST), .SCLK(SCLK),
  .CS_N(CS_N), .REPLY_DATA_OE(REPLY_DATA_OE), .IRQ_N_O(IRQ_N_O), .IRQ_N_OE(IRQ_N_OE),
  .GP_TMR_EVT(GP_TMR_EVT), .GP_TMR_PSAVE(GP_TMR_PSAVE), .RX_MEAS_PSAVE(RX_MEAS_PSAVE),
  .EVENT_FLAGS(EVENT_FLAGS));

//--- testbench.sv
`timescale 1ns/100ps
module testbench
  import tsp_pkg::*;
;
  logic        mclk = 0, nrst = 0, lgc = 0;
  logic [2:0]  evt = 0, ps = 0;
  logic [7:0]  rd;
  wire         sclk, cs_n, cmd_data, rep_o, rep_oe, irq_o, irq_oe, aud, sum;
  wire  [15:0] t1, t2;
  wire  [2:0]  flg;
  wire         rep = rep_oe ? rep_o : ~rep_o;
  wire         irq_n = irq_oe ? irq_o : 1'b1;
  int          n_fail = 0, n_tests = 0, k;
  logic [39:0] tab [6] = '{40'h30_F000_0003, 40'h31_1234_1234, 40'h32_ABCD_ABCD,
                           40'h35_5555_1234, 40'h30_8000_0002, 40'h30_1000_0001};
  tsp_host_port u_dut (.MCLK(mclk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n),
    .CMD_DATA(cmd_data), .REPLY_DATA_O(rep_o), .REPLY_DATA_OE(rep_oe), .IRQ_N_O(irq_o),
    .IRQ_N_OE(irq_oe), .LOGIC_IN(lgc), .GP_TMR_EVT(evt[0]), .NOTONE_EVT(evt[1]),
    .RX_MEAS_EVT(evt[2]), .GP_TMR_PSAVE(ps[0]), .NOTONE_PSAVE(ps[1]),
    .RX_MEAS_PSAVE(ps[2]), .AUDIO_SW_EN(aud), .SUM_SW_EN(sum), .TONE1_WORD(t1),
    .TONE2_WORD(t2), .EVENT_FLAGS(flg));
  tsp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .cmd_data(cmd_data), .reply(rep));
  initial forever #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task wt(input logic e);
    int i;
    for (i = 0; i < 10 && irq_n !== e; i++) @(negedge mclk);
    chk(irq_n, e);
    if (irq_n !== e) finish_test();
  endtask : wt
  task pulse(input logic [2:0] m);
    @(posedge mclk) evt <= m;
    @(posedge mclk) evt <= 3'h0;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task wr(input logic [7:0] c);
    u_host.frame({8'h30, c, 8'h00}, 16, rd);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1;
    repeat (4) @(posedge mclk);
    chk(rep_oe, 0);
    for (k = 0; k < 6; k++) begin
      u_host.frame(tab[k][39:16], tab[k][33:32] == 2'h0 ? 16 : 24, rd);
      chk(tab[k][33:32] == 2'h1 ? t1 : tab[k][33:32] == 2'h2 ? t2 : {14'h0000, aud, sum},
          tab[k][15:0]);
    end
    u_host.frame({8'h30, 8'hFF, 8'h00}, 12, rd);
    chk({aud, sum}, 1);
    wr(8'h60);
    pulse(3'h1);
    wt(0);
    chk(flg, 1);
    @(posedge mclk) lgc <= 1;
    repeat (6) @(posedge mclk);
    u_host.frame({8'h40, 16'h0000}, 16, rd);
    chk(rd, 8'h09);
    chk(rep_oe, 0);
    chk(flg, 0);
    wt(1);
    @(posedge mclk) ps <= 3'h7;
    pulse(3'h7);
    chk(flg, 0);
    wt(1);
    @(posedge mclk) ps <= 3'h0;
    wr(8'h00);
    pulse(3'h2);
    chk(flg, 2);
    chk(irq_n, 1);
    wr(8'h20);
    wt(0);
    u_host.frame({8'h40, 16'h0000}, 16, rd);
    chk(rd, 8'h0A);
    wt(1);
    wr(8'h40);
    pulse(3'h4);
    wt(0);
    chk(flg, 4);
    @(posedge mclk) nrst <= 0;
    repeat (2) @(posedge mclk);
    chk(irq_n, 1);
    chk({flg, aud, sum, t1[10:0]}, 0);
    chk(t2, 0);
    @(posedge mclk) nrst <= 1;
    repeat (4) @(posedge mclk);
    finish_test();
  end
endmodule : testbench
